// ### hw/acr_clk_div.sv
// acr_clk_div: derives the conversion clock from the converter source clock.
// assumes: the source clock is slower than half the system clock; it is sampled, not used as a clock.
`timescale 1ns/1ps
module acr_clk_div
  import acr_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  converter_source_clock,
  acr_ctrl_if.div    ctl
);

  acr_div_state_t s;
  acr_div_state_t next_s;
  logic [3:0]     half;

  always_comb begin
    next_s          = s;
    half            = acr_div_half(ctl.div_select, ctl.pll_enable);
    next_s.src_meta = converter_source_clock;
    next_s.src_sync = s.src_meta;
    next_s.src_prev = s.src_sync;
    // one step per rising source edge, toggle every half period
    if (s.src_sync && !s.src_prev) begin
      if (s.edge_cnt >= half - 4'h1) begin // [R01] [R02] [R03]
        next_s.edge_cnt   = 4'h0;
        next_s.conv_clock = ~s.conv_clock;
      end else begin
        next_s.edge_cnt = s.edge_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST_DIV_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign ctl.conv_clock = s.conv_clock;

endmodule : acr_clk_div

// ### hw/acr_ctrl_if.sv
// acr_ctrl_if: signals shared between the register front end, the divider and the flags.
// assumes: all three parties run on the same system clock.
`timescale 1ns/1ps
interface acr_ctrl_if;
  logic [2:0] div_select;
  logic       pll_enable;
  logic       conv_clock;
  logic [5:0] clear_mask;
  logic [5:0] ready_flags;
  logic [5:0] ready_events;

  modport ctrl  (output div_select, output pll_enable, output clear_mask,
                 input conv_clock, input ready_flags, input ready_events);
  modport div   (input div_select, input pll_enable, output conv_clock);
  modport flags (input clear_mask, output ready_flags, output ready_events);
endinterface : acr_ctrl_if

// ### hw/acr_pkg.sv
// acr_pkg: constants, state types and helpers for the converter clock and ready-status block.
// assumes: one system clock, synchronous active-low reset, AXI4-Lite register access.
package acr_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam int          AXI_ADDR_W      = 8;
  localparam logic [7:0]  OFS_CONTROL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_BASE        = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h10;
  localparam logic [7:0]  OFS_CLOCK_CFG   = 8'h14;

  // ---------------------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------------------
  localparam int          PAIRS           = 6;
  localparam int          DIV_SEL_LSB     = 0;
  localparam int          DIV_SEL_W       = 3;
  localparam int          BASE_HI_LSB     = 8;
  localparam int          BASE_HI_W       = 8;
  localparam int          PLL_EN_BIT      = 0;

  // ---------------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  RST_DIV_SEL     = 3'h0;
  localparam logic        RST_PLL_EN      = 1'h0;
  localparam logic [7:0]  RST_BASE_HI     = 8'h00;
  localparam logic [5:0]  RST_FLAGS       = 6'h00;
  localparam logic [5:0]  RST_IRQ_MASK    = 6'h00;

  // ---------------------------------------------------------------------------
  // divider ratios: ratio = base + step * code
  // ---------------------------------------------------------------------------
  localparam logic [4:0]  RATIO_BASE      = 5'h04;
  localparam logic [4:0]  RATIO_STEP      = 5'h02;
  localparam logic [2:0]  PLL_FLOOR_CODE  = 3'h2;

  // ---------------------------------------------------------------------------
  // bus responses
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    ACR_REG_CONTROL   = 3'h0,
    ACR_REG_STATUS    = 3'h1,
    ACR_REG_BASE      = 3'h3,
    ACR_REG_IRQ_STAT  = 3'h2,
    ACR_REG_IRQ_MASK  = 3'h6,
    ACR_REG_CLOCK_CFG = 3'h7,
    ACR_REG_NONE      = 3'h5
  } acr_reg_t;

  // half period of the conversion clock in source-clock edges
  function automatic logic [3:0] acr_div_half(input logic [2:0] code, input logic pll_en);
    logic [2:0] eff;
    logic [4:0] ratio;
    eff = code;
    if (pll_en && (code < PLL_FLOOR_CODE)) begin // [R02]
      eff = PLL_FLOOR_CODE;
    end
    ratio = RATIO_BASE + RATIO_STEP * {2'h0, eff}; // [R01] [R03]
    return ratio[4:1];
  endfunction : acr_div_half

  typedef struct packed {
    logic       src_meta;
    logic       src_sync;
    logic       src_prev;
    logic [3:0] edge_cnt;
    logic       conv_clock;
  } acr_div_state_t;

  localparam acr_div_state_t RST_DIV_STATE = '{1'h0, 1'h0, 1'h0, 4'h0, 1'h0};

  typedef struct packed {
    logic [5:0] flags;
    logic [5:0] events;
  } acr_flag_state_t;

  localparam acr_flag_state_t RST_FLAG_STATE = '{RST_FLAGS, 6'h00};

  typedef struct packed {
    logic                  aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [2:0]            div_select;
    logic                  pll_enable;
    logic [7:0]            base_hi;
    logic [5:0]            irq_status;
    logic [5:0]            irq_mask;
    logic                  irq;
  } acr_top_state_t;

  localparam acr_top_state_t RST_TOP_STATE = '{
    1'h0, 8'h00, 1'h0, 32'h0000_0000, 4'h0,
    1'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 32'h0000_0000, 2'h0,
    RST_DIV_SEL, RST_PLL_EN, RST_BASE_HI, 6'h00, RST_IRQ_MASK, 1'h0
  };

endpackage : acr_pkg

// ### hw/acr_ready_flags.sv
// acr_ready_flags: six per-pair ready flags, set by the converter, cleared by software.
// assumes: store pulses come from logic on the system clock.
`timescale 1ns/1ps
module acr_ready_flags
  import acr_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [5:0] pair_result_stored,
  acr_ctrl_if.flags       ctl
);

  acr_flag_state_t s;
  acr_flag_state_t next_s;

  always_comb begin
    next_s        = s;
    // set beats a clear in the same cycle
    next_s.flags  = (s.flags & ~ctl.clear_mask) | pair_result_stored; // [R06] [R07] [R09]
    next_s.events = pair_result_stored;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST_FLAG_STATE; // [R07]
    end else begin
      s <= next_s;
    end
  end

  assign ctl.ready_flags  = s.flags;
  assign ctl.ready_events = s.events;

endmodule : acr_ready_flags

// ### hw/acr_top.sv
// acr_top: converter clock select and pair ready status, reached over AXI4-Lite.
// assumes: one 40 MHz system clock, synchronous active-low reset, one write and one read at a time.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Contract
// R01: with pll on, codes 111..010 divide source clock by 18..8.
// R02: with pll on, codes 001 and 000 behave as divide by 8.
// R03: with pll off, codes 111..000 divide source clock by 18..4.
// R04: divider select sits in control register bits 2..0.
// R05: status holds six pair flags at bits 5..0; bits 15..6 read zero.
// R06: hardware sets a pair flag when its result is stored.
// R07: writing zero clears a flag; all flags reset to zero.
// R08: base register bits 15..8 are read/write, reset to zero.
// R09: writing one leaves a flag alone; set wins over a same-cycle clear.
module acr_top
  import acr_pkg::*;
(
  input  wire  logic                           aclk,
  input  wire  logic                           aresetn,
  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  input  wire  logic                           s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire  logic [acr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic                           s_axi_wvalid,
  output logic                                 s_axi_wready,
  input  wire  logic [31:0]                    s_axi_wdata,
  input  wire  logic [3:0]                     s_axi_wstrb,
  output logic                                 s_axi_bvalid,
  input  wire  logic                           s_axi_bready,
  output logic [1:0]                           s_axi_bresp,
  input  wire  logic                           s_axi_arvalid,
  output logic                                 s_axi_arready,
  input  wire  logic [acr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  output logic                                 s_axi_rvalid,
  input  wire  logic                           s_axi_rready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  // ---------------------------------------------------------------------------
  // converter side
  // ---------------------------------------------------------------------------
  input  wire  logic                           converter_source_clock,
  input  wire  logic [5:0]                     pair_result_stored,
  output logic                                 conv_clock,
  output logic [5:0]                           pair_ready,
  output logic                                 irq
);

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  function automatic acr_reg_t acr_decode(input logic [AXI_ADDR_W-1:0] addr);
    acr_reg_t r;
    case (addr)
      OFS_CONTROL:    r = ACR_REG_CONTROL;
      OFS_STATUS:     r = ACR_REG_STATUS;
      OFS_BASE:       r = ACR_REG_BASE;
      OFS_IRQ_STATUS: r = ACR_REG_IRQ_STAT;
      OFS_IRQ_MASK:   r = ACR_REG_IRQ_MASK;
      OFS_CLOCK_CFG:  r = ACR_REG_CLOCK_CFG;
      default:        r = ACR_REG_NONE;
    endcase
    return r;
  endfunction : acr_decode

  acr_ctrl_if     ctl ();
  acr_top_state_t s;
  acr_top_state_t next_s;
  acr_reg_t       wr_reg;
  acr_reg_t       rd_reg;
  logic           wr_fire;
  logic           rd_fire;
  logic [5:0]     clear_mask;
  logic [5:0]     irq_clear;

  // ---------------------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------------------
  acr_clk_div u_clk_div (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .converter_source_clock (converter_source_clock),
    .ctl                    (ctl)
  );

  acr_ready_flags u_ready_flags (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .pair_result_stored (pair_result_stored),
    .ctl                (ctl)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_s     = s;
    clear_mask = 6'h00;
    irq_clear  = 6'h00;
    wr_reg     = acr_decode(s.aw_addr);
    rd_reg     = acr_decode(s_axi_araddr);
    wr_fire    = s.aw_held && s.w_held && !s.bvalid;
    rd_fire    = s_axi_arvalid && s.arready;

    // write address and data are taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'h1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'h1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end

    // response completes the write
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'h0;
    end

    // register update once both halves are held
    if (wr_fire) begin
      next_s.aw_held = 1'h0;
      next_s.w_held  = 1'h0;
      next_s.bvalid  = 1'h1;
      next_s.bresp   = RESP_OKAY;
      case (wr_reg)
        ACR_REG_CONTROL: begin
          if (s.w_strb[0]) begin
            next_s.div_select = s.w_data[DIV_SEL_LSB +: DIV_SEL_W]; // [R04]
          end
        end
        ACR_REG_STATUS: begin
          // zero clears, one leaves the flag alone
          if (s.w_strb[0]) begin
            clear_mask = ~s.w_data[PAIRS-1:0]; // [R07] [R09]
          end
        end
        ACR_REG_BASE: begin
          if (s.w_strb[1]) begin
            next_s.base_hi = s.w_data[BASE_HI_LSB +: BASE_HI_W]; // [R08]
          end
        end
        ACR_REG_IRQ_STAT: begin
          if (s.w_strb[0]) begin
            irq_clear = s.w_data[PAIRS-1:0];
          end
        end
        ACR_REG_IRQ_MASK: begin
          if (s.w_strb[0]) begin
            next_s.irq_mask = s.w_data[PAIRS-1:0];
          end
        end
        ACR_REG_CLOCK_CFG: begin
          if (s.w_strb[0]) begin
            next_s.pll_enable = s.w_data[PLL_EN_BIT];
          end
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read answers one cycle after the address is taken
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'h0;
    end
    if (rd_fire) begin
      next_s.rvalid = 1'h1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      case (rd_reg)
        ACR_REG_CONTROL: begin
          next_s.rdata[DIV_SEL_LSB +: DIV_SEL_W] = s.div_select; // [R04]
        end
        ACR_REG_STATUS: begin
          // upper bits stay zero
          next_s.rdata[PAIRS-1:0] = ctl.ready_flags; // [R05]
        end
        ACR_REG_BASE: begin
          next_s.rdata[BASE_HI_LSB +: BASE_HI_W] = s.base_hi; // [R08]
        end
        ACR_REG_IRQ_STAT: begin
          next_s.rdata[PAIRS-1:0] = s.irq_status;
        end
        ACR_REG_IRQ_MASK: begin
          next_s.rdata[PAIRS-1:0] = s.irq_mask;
        end
        ACR_REG_CLOCK_CFG: begin
          next_s.rdata[PLL_EN_BIT] = s.pll_enable;
        end
        default: begin
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // ---------------------------------------------------------------------------
    // interrupt: sticky, write one to clear, new event wins
    // ---------------------------------------------------------------------------
    next_s.irq_status = (s.irq_status & ~irq_clear) | ctl.ready_events;
    next_s.irq        = |(next_s.irq_status & next_s.irq_mask);

    // ready lines follow the held state so the ports come from flops
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST_TOP_STATE;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign ctl.div_select = s.div_select;
  assign ctl.pll_enable = s.pll_enable;
  assign ctl.clear_mask = clear_mask;

  assign s_axi_awready  = s.awready;
  assign s_axi_wready   = s.wready;
  assign s_axi_bvalid   = s.bvalid;
  assign s_axi_bresp    = s.bresp;
  assign s_axi_arready  = s.arready;
  assign s_axi_rvalid   = s.rvalid;
  assign s_axi_rdata    = s.rdata;
  assign s_axi_rresp    = s.rresp;
  assign conv_clock     = ctl.conv_clock;
  assign pair_ready     = ctl.ready_flags;
  assign irq            = s.irq;

endmodule : acr_top

// ### verification/acr_top_asserts.sv
// acr_top_asserts: concurrent checks on the ports of acr_top.
// assumes: bound to acr_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module acr_top_asserts
  import acr_pkg::*;
(
  input wire logic                           aclk,
  input wire logic                           aresetn,
  input wire logic                           s_axi_awready,
  input wire logic                           s_axi_wready,
  input wire logic                           s_axi_bvalid,
  input wire logic                           s_axi_arvalid,
  input wire logic                           s_axi_arready,
  input wire logic [acr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                           s_axi_rvalid,
  input wire logic [31:0]                    s_axi_rdata,
  input wire logic [1:0]                     s_axi_rresp,
  input wire logic [5:0]                     pair_result_stored,
  input wire logic [5:0]                     pair_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_flag_set;
    pair_result_stored != 6'h00 |=> (pair_ready & $past(pair_result_stored)) == $past(pair_result_stored);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set after store");

  property p_flag_rise;
    (pair_ready & ~$past(pair_ready) & ~$past(pair_result_stored)) == 6'h00;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without store");

  property p_flag_fall;
    (~pair_ready & $past(pair_ready)) != 6'h00 |-> $rose(s_axi_bvalid);
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without write");

  property p_status_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STATUS
      |=> s_axi_rvalid && s_axi_rdata == {26'h0, $past(pair_ready)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_base_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_BASE
      |=> s_axi_rdata[7:0] == 8'h00 && s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_base_read: assert property (p_base_read) else $error("base unused bits nonzero");

  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");

  property p_b_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken during response");

  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken during response");
endmodule : acr_top_asserts

bind acr_top acr_top_asserts acr_top_asserts_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .pair_result_stored,
  .pair_ready);

// ### verification/tb_top.sv
// tb_top: self-checking bench for acr_top over AXI4-Lite.
// assumes: acr_pkg compiled first; checker bound separately.
`timescale 1ns/1ps
module tb_top;
  import acr_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_clock, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        converter_source_clock = 1'b0;
  logic [5:0]  pair_result_stored = 6'h00;
  logic [5:0]  pair_ready;
  logic [31:0] seed = 32'hea97;
  int          miscompares = 0;
  int          num_checks = 0;
  int          src_cnt = 0;

  acr_top acr_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .converter_source_clock, .pair_result_stored, .conv_clock, .pair_ready, .irq);

  always #12.5 aclk = ~aclk;

  // source clock: each level three system cycles
  always @(posedge aclk) begin
    src_cnt <= (src_cnt == 2) ? 0 : src_cnt + 1;
    if (src_cnt == 2) converter_source_clock <= ~converter_source_clock;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic int exp_ratio(input logic [2:0] c, input logic p);
    return 4 + 2 * ((p && c < 3'h2) ? 2 : c);
  endfunction : exp_ratio

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic pulse(input logic [5:0] v);
    @(posedge aclk) pair_result_stored <= v;
    @(posedge aclk) pair_result_stored <= 6'h00;
  endtask : pulse

  task automatic rise(inout int n);
    logic prev;
    do begin
      prev = conv_clock;
      @(posedge aclk);
      n++;
    end while (!(conv_clock === 1'b1 && prev === 1'b0) && n < 400);
  endtask : rise

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] d, m, q, f;
    logic [1:0]  r;
    logic [7:0]  a;
    int          n;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    a = 8'h00;
    for (int i = 0; i < 6; i++) begin
      rd(a, q, r);
      chk_val(q, 32'h0);
      a = a + 8'h04;
    end
    wr(8'h40, rnd(), 4'hf, r);
    chk_resp(r, RESP_SLVERR);
    rd(8'h40, q, r);
    chk_resp(r, RESP_SLVERR);
    $display("test reset_map done");
    repeat (4) begin
      d = rnd();
      wr(OFS_BASE, d, 4'h2, r);
      rd(OFS_BASE, q, r);
      chk_val(q, {16'h0, d[15:8], 8'h00});
    end
    $display("test base done");
    for (int i = 0; i < 16; i++) begin
      wr(OFS_CLOCK_CFG, {31'h0, i[3]}, 4'hf, r);
      wr(OFS_CONTROL, (rnd() & 32'hfff8) | i[2:0], 4'h1, r);
      rd(OFS_CONTROL, q, r);
      chk_val(q, {29'h0, i[2:0]});
      n = 0;
      rise(n);
      rise(n);
      n = 0;
      rise(n);
      chk_val(n, 6 * exp_ratio(i[2:0], i[3]));
    end
    $display("test divider done");
    // flags left standing by one round carry into the next
    f = 32'h0;
    repeat (4) begin
      m = (rnd() & 32'h3f) | 32'h1;
      f = f | m;
      pulse(m[5:0]);
      rd(OFS_STATUS, q, r);
      chk_val(q, f);
      chk_val({26'h0, pair_ready}, f);
      d = rnd();
      wr(OFS_STATUS, d, 4'h1, r);
      f = f & d;
      rd(OFS_STATUS, q, r);
      chk_val(q, f);
    end
    fork
      wr(OFS_STATUS, 32'h0, 4'h1, r);
      begin @(posedge aclk); pulse(6'h15); end
    join
    rd(OFS_STATUS, q, r);
    chk_val(q, 32'h15);
    $display("test flags done");
    wr(OFS_IRQ_MASK, 32'h3f, 4'h1, r);
    wr(OFS_IRQ_STATUS, 32'h3f, 4'h1, r);
    pulse(6'h04);
    repeat (3) @(posedge aclk);
    chk_val({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STATUS, q, r);
    chk_val(q, 32'h04);
    wr(OFS_IRQ_STATUS, 32'h04, 4'h1, r);
    repeat (2) @(posedge aclk);
    chk_val({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0, 4'h1, r);
    pulse(6'h08);
    repeat (3) @(posedge aclk);
    chk_val({31'h0, irq}, 32'h0);
    rd(OFS_IRQ_STATUS, q, r);
    chk_val(q, 32'h08);
    $display("test irq done");
    @(posedge aclk) aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS, q, r);
    chk_val(q, 32'h0);
    rd(OFS_BASE, q, r);
    chk_val(q, 32'h0);
    $display("test second_reset done");
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
endmodule : tb_top
